// *** bench/flash_host.sv ***
// Purpose: Behavioural host that drives the flash bus pins and query mode
// Assumes: Pins change by non-blocking assignment just after a rising edge
// Notes:   Address lines go to the inverse of the last word once deselected

`timescale 1ns/1ps

module flash_host
    import query_rom_pkg::*;
(
    // Clock of the device side
    input  wire logic                  clock,
    // Bus pins toward the device
    output logic                       chip_en_n,
    output logic                       out_en_n,
    output logic      [ADDR_WIDTH-1:0] addr,
    // Query mode level
    output logic                       query_active
);
    // Deselected at time zero
    initial begin
        chip_en_n    = 1'b1;
        out_en_n     = 1'b1;
        addr         = 9'h000;
        query_active = 1'b0;
    end

    // Select a word and hold it three edges, the pin latency of the reply
    task automatic access(input logic [ADDR_WIDTH-1:0] a);
        @(posedge clock);
        chip_en_n <= 1'b0;
        out_en_n  <= 1'b0;
        addr      <= a;
        repeat (3) @(posedge clock);
    endtask : access

    // Stale address is never left on the lines
    task automatic release_bus();
        @(posedge clock);
        chip_en_n <= 1'b1;
        out_en_n  <= 1'b1;
        addr      <= ~addr;
    endtask : release_bus

    task automatic set_query(input logic v);
        @(posedge clock);
        query_active <= v;
    endtask : set_query
endmodule : flash_host

// *** bench/test_query_rom.sv ***
// Purpose: Self-checking bench for the extended query table
// Assumes: Host model holds each word for the full three edge latency
// Notes:   Expected words come from a small model table, not the design

`timescale 1ns/1ps

module test_query_rom;
    import query_rom_pkg::*;
    localparam logic [15:0] THIRD = 16'h005A; // Value is arbitrary
    logic                  CLOCK = 1'b0;
    logic                  RST_N = 1'b0;
    logic                  CHIP_EN_N;
    logic                  OUT_EN_N;
    logic                  QUERY_ACTIVE;
    logic [ADDR_WIDTH-1:0] ADDR;
    logic [DATA_WIDTH-1:0] DQ_OUT;
    logic                  DQ_OE;
    logic                  TABLE_HIT;
    int                    err_count = 0;
    int                    comparisons = 0;
    logic [31:0]           seed = 32'd68597;
    logic [31:0]           caps;
    logic [7:0]            cap_bytes[$];

    // Clock of 100 ns period
    always #50 CLOCK = ~CLOCK;

    query_rom #(.SIGNATURE_THIRD_CHAR(THIRD)) i_query_rom (
        .CLOCK(CLOCK), .RST_N(RST_N), .CHIP_EN_N(CHIP_EN_N), .OUT_EN_N(OUT_EN_N),
        .ADDR(ADDR), .QUERY_ACTIVE(QUERY_ACTIVE), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
        .TABLE_HIT(TABLE_HIT));

    flash_host i_flash_host (
        .clock(CLOCK), .chip_en_n(CHIP_EN_N), .out_en_n(OUT_EN_N), .addr(ADDR),
        .query_active(QUERY_ACTIVE));

    // Table model; -1 marks an unmapped offset
    function automatic int model(input int adr);
        case (adr)
            'h015: return 'h000A;
            'h016: return 'h0001;
            'h10A: return 'h0050;
            'h10B: return 'h0052;
            'h10C: return int'(THIRD);
            'h10D: return 'h0031;
            'h10E: return 'h0033;
            'h10F: return 'h00E6;
            'h110: return 'h0000;
            'h111: return 'h0003;
            'h112: return 'h0000;
            'h113: return 'h0001;
            'h114: return 'h0003;
            'h115: return 'h0000;
            'h116: return 'h0018;
            'h117: return 'h0090;
            default: return -1;
        endcase
    endfunction : model

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : check

    // Read one word and compare enable, hit and data with the model, or with all zero when query mode is off
    task automatic read_expect(input int adr, input logic q);
        int m;
        i_flash_host.access(adr[8:0]);
        #1;
        m = model(adr);
        if (!q) check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h0_0000);
        else if (m < 0) check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h2_0000);
        else check({DQ_OE, TABLE_HIT, DQ_OUT}, {2'b11, m[15:0]});
    endtask : read_expect

    task automatic conclude();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #2_000_000;
        err_count++;
        conclude();
    end

    // Main sequence
    initial begin
        // Outputs stay unknown until the first edge applies the reset
        @(posedge CLOCK);
        #1;
        check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h0_0000);
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        read_expect('h10A, 1'b0);
        i_flash_host.set_query(1'b1);
        for (int a = 'h108; a <= 'h119; a++) read_expect(a, 1'b1);
        read_expect('h015, 1'b1);
        read_expect('h016, 1'b1);
        read_expect('h1FF, 1'b1);
        $display("test table sweep done");
        for (int i = 0; i < 4; i++) begin
            read_expect('h10F + i, 1'b1);
            cap_bytes.push_back(DQ_OUT[7:0]);
        end
        // Bytes of 10Fh, 111h, 112h; the 110h gap word stands in for the zero top byte
        caps = {cap_bytes[1], cap_bytes[3], cap_bytes[2], cap_bytes[0]};
        check({2'b00, caps[15:0]}, 18'h0_03E6);
        check({2'b00, caps[31:16]}, 18'h0_0000);
        $display("test capability field done");
        read_expect('h116, 1'b1);
        i_flash_host.set_query(1'b0);
        @(posedge CLOCK);
        #1;
        check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h0_0000);
        i_flash_host.set_query(1'b1);
        read_expect('h117, 1'b1);
        i_flash_host.release_bus();
        repeat (2) @(posedge CLOCK);
        #1;
        check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h3_0090);
        @(posedge CLOCK);
        #1;
        check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h0_0000);
        $display("test query exit and release done");
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            read_expect(seed[9] ? 'h10A + seed[3:0] : seed[8:0], 1'b1);
        end
        $display("test random reads done");
        read_expect('h113, 1'b1);
        @(posedge CLOCK);
        RST_N <= 1'b0;
        #1;
        check({DQ_OE, TABLE_HIT, DQ_OUT}, 18'h0_0000);
        @(posedge CLOCK);
        RST_N <= 1'b1;
        read_expect('h114, 1'b1);
        read_expect('h115, 1'b1);
        $display("test mid-run reset done");
        conclude();
    end
endmodule : test_query_rom

// *** common/query_rom_pkg.sv ***
// Purpose: Shared constants and types for the extended query table block
// Assumes: 16-bit flash data bus, word addressing, query words on the low byte
// Notes:   Each table offset, and each word value but the third signature character, is named once here

package query_rom_pkg;

    // Bus widths of the parallel flash interface
    localparam int ADDR_WIDTH = 9;
    localparam int DATA_WIDTH = 16;
    localparam int LOW_WIDTH  = 8;

    // Word offsets of the query space served here
    localparam logic [8:0] OFS_BASE_POINTER_LOW  = 9'h015;
    localparam logic [8:0] OFS_BASE_POINTER_HIGH = 9'h016;
    localparam logic [8:0] OFS_SIGNATURE_FIRST   = 9'h10A;
    localparam logic [8:0] OFS_SIGNATURE_SECOND  = 9'h10B;
    localparam logic [8:0] OFS_SIGNATURE_THIRD   = 9'h10C;
    localparam logic [8:0] OFS_MAJOR_VERSION     = 9'h10D;
    localparam logic [8:0] OFS_MINOR_VERSION     = 9'h10E;
    localparam logic [8:0] OFS_FEATURE_LOW       = 9'h10F;
    localparam logic [8:0] OFS_FEATURE_GAP       = 9'h110;
    localparam logic [8:0] OFS_FEATURE_B         = 9'h111;
    localparam logic [8:0] OFS_FEATURE_C         = 9'h112;
    localparam logic [8:0] OFS_SUSPEND_FUNCS     = 9'h113;
    localparam logic [8:0] OFS_PROTECT_LOW       = 9'h114;
    localparam logic [8:0] OFS_PROTECT_HIGH      = 9'h115;
    localparam logic [8:0] OFS_CORE_SUPPLY       = 9'h116;
    localparam logic [8:0] OFS_PROGRAM_SUPPLY    = 9'h117;

    // Feature bit positions in the capability field
    localparam int FEAT_CHIP_ERASE      = 0;
    localparam int FEAT_ERASE_SUSPEND   = 1;
    localparam int FEAT_PROGRAM_SUSPEND = 2;
    localparam int FEAT_LEGACY_LOCK     = 3;
    localparam int FEAT_QUEUED_ERASE    = 4;
    localparam int FEAT_INSTANT_LOCK    = 5;
    localparam int FEAT_PROTECT_BITS    = 6;
    localparam int FEAT_PAGE_READ       = 7;
    localparam int FEAT_SYNC_READ       = 8;
    localparam int FEAT_SIMULTANEOUS    = 9;
    localparam int FEAT_MORE_FOLLOWS    = 31;

    // Capability field; bits 10 and up are zero, no further field follows
    localparam logic [31:0] FEATURE_SUPPORT = 32'h0000_03E6;

    // Word values of the table
    localparam logic [15:0] VAL_BASE_POINTER_LOW  = 16'h000A;
    localparam logic [15:0] VAL_BASE_POINTER_HIGH = 16'h0001;
    localparam logic [15:0] VAL_SIGNATURE_FIRST   = 16'h0050;
    localparam logic [15:0] VAL_SIGNATURE_SECOND  = 16'h0052;
    localparam logic [15:0] VAL_MAJOR_VERSION     = 16'h0031;
    localparam logic [15:0] VAL_MINOR_VERSION     = 16'h0033;
    localparam logic [15:0] VAL_FEATURE_LOW       = {8'h00, FEATURE_SUPPORT[7:0]};
    localparam logic [15:0] VAL_FEATURE_GAP       = 16'h0000;
    localparam logic [15:0] VAL_FEATURE_B         = {8'h00, FEATURE_SUPPORT[15:8]};
    localparam logic [15:0] VAL_FEATURE_C         = {8'h00, FEATURE_SUPPORT[23:16]};
    localparam logic [15:0] VAL_SUSPEND_FUNCS     = 16'h0001;
    localparam logic [15:0] VAL_PROTECT_LOW       = 16'h0003;
    localparam logic [15:0] VAL_PROTECT_HIGH      = 16'h0000;
    localparam logic [15:0] VAL_CORE_SUPPLY       = 16'h0018;
    localparam logic [15:0] VAL_PROGRAM_SUPPLY    = 16'h0090;

    // Value on the data lines when nothing is driven or the offset is unmapped
    localparam logic [15:0] RESET_DATA = 16'h0000;

    // Host bus request as seen on the pins
    typedef struct packed {
        logic                  chip_en_n;
        logic                  out_en_n;
        logic [ADDR_WIDTH-1:0] addr;
    } bus_req_type;

    // Deselected bus, used as synchroniser reset value
    localparam bus_req_type REQ_IDLE = '{chip_en_n: 1'b1, out_en_n: 1'b1, addr: 9'h000};

endpackage : query_rom_pkg

// *** logic/query_rom.sv ***
// Purpose: Primary-algorithm extended query table served on the flash data bus
// Assumes: QUERY_ACTIVE comes from the command decoder on the same clock
// Notes:   Bus pins are synchronised; data follows three edges later
//
// Summary of operation
// - Offsets 10Ah onward give three signature words, 0050h then 0052h first.
// - Offset 10Dh returns major version 0031h.
// - Offset 10Eh returns minor version 0033h.
// - Capability low word 00E6h at 10Fh, then 0003h at 111h, 0000h at 112h.
// - Capability bits 0 to 9 set means that feature is supported.
// - Capability bits 10 to 31 are zero; bit 31 would flag more fields.
// - Offset 113h returns 0001h: program allowed during erase suspend.
// - Offsets 114h and 115h return 0003h and 0000h for protect status bits.
// - Offset 116h returns 0018h, core supply in volts and BCD tenths.
// - Offset 117h returns 0090h, programming supply in the same encoding.
// - Table is visible only while query mode is active.
// - Query values use only the low data lines; upper lines read zero.
// - Offsets 015h and 016h point to the table with 000Ah and 0001h.

`timescale 1ns/1ps

module query_rom
    import query_rom_pkg::*;
#(
    // Third signature character; value is arbitrary
    parameter logic [15:0] SIGNATURE_THIRD_CHAR = 16'h0000
) (
    // Clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RST_N,
    // Host bus pins
    input  wire logic                  CHIP_EN_N,
    input  wire logic                  OUT_EN_N,
    input  wire logic [ADDR_WIDTH-1:0] ADDR,
    // Query mode level from the command decoder
    input  wire logic                  QUERY_ACTIVE,
    // Data lines toward the host
    output logic      [DATA_WIDTH-1:0] DQ_OUT,
    output logic                       DQ_OE,
    // Offset decoded as a table word
    output logic                       TABLE_HIT
);

    bus_req_type                 pin_req;
    logic        [$bits(bus_req_type)-1:0] req_bits;
    bus_req_type                 req;
    logic                        read_req;
    logic                        rom_hit;
    logic        [DATA_WIDTH-1:0] rom_word;
    logic        [DATA_WIDTH-1:0] next_dq_out;
    logic                        next_dq_oe;
    logic                        next_table_hit;

    // Pins gathered into one request before crossing
    assign pin_req = {CHIP_EN_N, OUT_EN_N, ADDR};

    // Whole request crosses together; host must hold address while reading
    sync_stage #(
        .WIDTH       ($bits(bus_req_type)),
        .RESET_VALUE (REQ_IDLE)
    ) u_req_sync (
        .clock    (CLOCK),
        .rst_n    (RST_N),
        .async_in (pin_req),
        .sync_out (req_bits)
    );

    assign req = bus_req_type'(req_bits);

    assign read_req = !req.chip_en_n && !req.out_en_n && QUERY_ACTIVE;

    // Table lookup; unmapped offsets give zero rather than stale data
    always_comb begin
        rom_hit  = 1'b1;
        rom_word = RESET_DATA;
        case (req.addr)
            OFS_BASE_POINTER_LOW:  rom_word = VAL_BASE_POINTER_LOW;
            OFS_BASE_POINTER_HIGH: rom_word = VAL_BASE_POINTER_HIGH;
            OFS_SIGNATURE_FIRST:   rom_word = VAL_SIGNATURE_FIRST;
            OFS_SIGNATURE_SECOND:  rom_word = VAL_SIGNATURE_SECOND;
            OFS_SIGNATURE_THIRD:   rom_word = SIGNATURE_THIRD_CHAR;
            OFS_MAJOR_VERSION:     rom_word = VAL_MAJOR_VERSION;
            OFS_MINOR_VERSION:     rom_word = VAL_MINOR_VERSION;
            // Capability low word from feature field, then the constant zero gap word
            OFS_FEATURE_LOW:       rom_word = VAL_FEATURE_LOW;
            OFS_FEATURE_GAP:       rom_word = VAL_FEATURE_GAP;
            // Upper capability bytes from feature field; only bits 8 and 9 come out set
            OFS_FEATURE_B:         rom_word = VAL_FEATURE_B;
            OFS_FEATURE_C:         rom_word = VAL_FEATURE_C;
            OFS_SUSPEND_FUNCS:     rom_word = VAL_SUSPEND_FUNCS;
            OFS_PROTECT_LOW:       rom_word = VAL_PROTECT_LOW;
            OFS_PROTECT_HIGH:      rom_word = VAL_PROTECT_HIGH;
            OFS_CORE_SUPPLY:       rom_word = VAL_CORE_SUPPLY;
            OFS_PROGRAM_SUPPLY:    rom_word = VAL_PROGRAM_SUPPLY;
            default: begin
                rom_hit  = 1'b0;
                rom_word = RESET_DATA;
            end
        endcase
    end

    // Next output values; lines return to zero when released
    always_comb begin
        next_dq_oe     = read_req;
        next_table_hit = read_req && rom_hit;
        next_dq_out    = RESET_DATA;
        if (read_req) begin
            next_dq_out = {{(DATA_WIDTH-LOW_WIDTH){1'b0}}, rom_word[LOW_WIDTH-1:0]};
        end
    end

    // Output flip-flops
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            DQ_OUT    <= RESET_DATA;
            DQ_OE     <= 1'b0;
            TABLE_HIT <= 1'b0;
        end else begin
            DQ_OUT    <= next_dq_out;
            DQ_OE     <= next_dq_oe;
            TABLE_HIT <= next_table_hit;
        end
    end

    // Checks on the served table
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // A synchronised read of one offset
    sequence s_read_at(logic [8:0] ofs);
        read_req && (req.addr == ofs);
    endsequence

    // A read held on one offset over two cycles
    sequence s_read_held;
        (read_req && $stable(req.addr)) [*2];
    endsequence

    property p_signature;
        (s_read_at(OFS_SIGNATURE_FIRST) |=> DQ_OE && DQ_OUT == VAL_SIGNATURE_FIRST) and
        (s_read_at(OFS_SIGNATURE_SECOND) |=> DQ_OE && DQ_OUT == VAL_SIGNATURE_SECOND);
    endproperty
    a_signature: assert property (p_signature)
        else $error("signature word wrong");

    property p_major;
        s_read_at(OFS_MAJOR_VERSION) |=> DQ_OUT == VAL_MAJOR_VERSION && TABLE_HIT;
    endproperty
    a_major: assert property (p_major)
        else $error("major version wrong");

    property p_minor;
        s_read_at(OFS_MINOR_VERSION) |=> DQ_OUT == VAL_MINOR_VERSION && TABLE_HIT;
    endproperty
    a_minor: assert property (p_minor)
        else $error("minor version wrong");

    property p_feature_words;
        (s_read_at(OFS_FEATURE_LOW) |=> DQ_OUT == 16'h00E6) and
        (s_read_at(OFS_FEATURE_B) |=> DQ_OUT == 16'h0003) and
        (s_read_at(OFS_FEATURE_C) |=> DQ_OUT == 16'h0000);
    endproperty
    a_feature_words: assert property (p_feature_words)
        else $error("capability words wrong");

    property p_feature_bits;
        s_read_at(OFS_FEATURE_LOW) |=> !DQ_OUT[FEAT_CHIP_ERASE] && DQ_OUT[FEAT_ERASE_SUSPEND]
            && DQ_OUT[FEAT_PROGRAM_SUSPEND] && !DQ_OUT[FEAT_LEGACY_LOCK]
            && !DQ_OUT[FEAT_QUEUED_ERASE] && DQ_OUT[FEAT_INSTANT_LOCK]
            && DQ_OUT[FEAT_PROTECT_BITS] && DQ_OUT[FEAT_PAGE_READ];
    endproperty
    a_feature_bits: assert property (p_feature_bits)
        else $error("feature support bits wrong");

    property p_feature_rsvd;
        s_read_at(OFS_FEATURE_B) |=> DQ_OUT[FEAT_SYNC_READ-LOW_WIDTH]
            && DQ_OUT[FEAT_SIMULTANEOUS-LOW_WIDTH] && DQ_OUT[7:2] == 6'h00;
    endproperty
    a_feature_rsvd: assert property (p_feature_rsvd)
        else $error("reserved capability bits set");

    property p_suspend;
        s_read_at(OFS_SUSPEND_FUNCS) |=> DQ_OUT == VAL_SUSPEND_FUNCS && DQ_OE;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend functions word wrong");

    property p_protect;
        (s_read_at(OFS_PROTECT_LOW) |=> DQ_OUT == VAL_PROTECT_LOW) and
        (s_read_at(OFS_PROTECT_HIGH) |=> DQ_OUT == VAL_PROTECT_HIGH && TABLE_HIT);
    endproperty
    a_protect: assert property (p_protect)
        else $error("block protect status wrong");

    property p_supplies;
        (s_read_at(OFS_CORE_SUPPLY) |=> DQ_OUT == VAL_CORE_SUPPLY) and
        (s_read_at(OFS_PROGRAM_SUPPLY) |=> DQ_OUT == VAL_PROGRAM_SUPPLY);
    endproperty
    a_supplies: assert property (p_supplies)
        else $error("supply voltage word wrong");

    property p_query_gate;
        !QUERY_ACTIVE |=> !DQ_OE && !TABLE_HIT && DQ_OUT == RESET_DATA;
    endproperty
    a_query_gate: assert property (p_query_gate)
        else $error("table driven outside query mode");

    // Reset is part of the window: the edge that releases it still clears the pipe
    property p_pin_latency;
        (RST_N && !CHIP_EN_N && !OUT_EN_N && QUERY_ACTIVE) [*4] |-> DQ_OE;
    endproperty
    a_pin_latency: assert property (p_pin_latency)
        else $error("read not answered in three edges");

    property p_upper_zero;
        s_read_held |=> DQ_OUT[DATA_WIDTH-1:LOW_WIDTH] == 8'h00 && $stable(DQ_OUT);
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper data lines carry data");

    property p_pointer;
        (s_read_at(OFS_BASE_POINTER_LOW) |=> DQ_OUT == VAL_BASE_POINTER_LOW) and
        (s_read_at(OFS_BASE_POINTER_HIGH) |=> DQ_OUT == VAL_BASE_POINTER_HIGH);
    endproperty
    a_pointer: assert property (p_pointer)
        else $error("table base pointer wrong");

    property p_gap;
        s_read_at(OFS_FEATURE_GAP) |=> DQ_OUT == VAL_FEATURE_GAP && TABLE_HIT;
    endproperty
    a_gap: assert property (p_gap)
        else $error("capability gap word not zero");

endmodule : query_rom

// *** logic/sync_stage.sv ***
// Purpose: Two flip-flop synchroniser for a group of pin levels
// Assumes: Grouped bits are held stable by the source long enough to settle
// Notes:   First stage is read only by the second stage

`timescale 1ns/1ps

module sync_stage #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Levels from outside the clock domain
    input  wire logic [WIDTH-1:0] async_in,
    // Levels safe to use in the clock domain
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    // Next values of both stages
    always_comb begin
        next_stage_one = async_in;
        next_sync_out  = stage_one;
    end

    // Both stages reset to a constant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_one <= RESET_VALUE;
            sync_out  <= RESET_VALUE;
        end else begin
            stage_one <= next_stage_one;
            sync_out  <= next_sync_out;
        end
    end

endmodule : sync_stage
